/* include/osc_ctrl_pkg.sv */
/*
  Constants for the oscillator clock-select block: register offsets, field
  positions, reset values and source codes.
  Assumes a 32-bit APB slave with word-aligned registers.
*/
package osc_ctrl_pkg;
  // Register byte offsets
  localparam logic [11:0] oscillator_control_off = 12'h000;
  localparam logic [11:0] unlock_key_off = 12'h004;
  localparam logic [11:0] osc_status_in_off = 12'h008;

  // Unlock key words, written in this order
  localparam logic [31:0] key_first = 32'haa99_6655;
  localparam logic [31:0] key_second = 32'h5566_99aa;

  // Field positions
  localparam int pos_odiv = 27;
  localparam int pos_fast_rc_divide = 24;
  localparam int pos_sosc_rdy = 22;
  localparam int pos_bus_rdy = 21;
  localparam int pos_busdiv = 19;
  localparam int pos_mult = 16;
  localparam int pos_cur = 12;
  localparam int pos_new = 8;
  localparam int pos_lock = 7;
  localparam int pos_usb_lock = 6;
  localparam int pos_sys_lock = 5;
  localparam int pos_sleep = 4;
  localparam int pos_fail = 3;
  localparam int pos_usb_rc = 2;
  localparam int pos_sosc_en = 1;
  localparam int pos_switch = 0;

  // Reset values; all but the fast RC divider are reloaded from configuration
  localparam logic [2:0] rst_fast_rc_divide = 3'h1;
  localparam logic [1:0] rst_busdiv = 2'h3;
  localparam logic [2:0] rst_mult = 3'h0;
  localparam logic [2:0] rst_odiv = 3'h0;

  // Divider ratio table shared by the output divider and the fast RC divider
  localparam logic [8:0] div_1 = 9'h001;
  localparam logic [8:0] div_2 = 9'h002;
  localparam logic [8:0] div_4 = 9'h004;
  localparam logic [8:0] div_8 = 9'h008;
  localparam logic [8:0] div_16 = 9'h010;
  localparam logic [8:0] div_32 = 9'h020;
  localparam logic [8:0] div_64 = 9'h040;
  localparam logic [8:0] div_256 = 9'h100;
  localparam logic [4:0] mult_base = 5'h0f;
  localparam logic [4:0] mult_top = 5'h18;

  // Clock source codes
  typedef enum logic [2:0] {
    src_frc = 3'h0,
    src_frc_pll = 3'h1,
    src_pri = 3'h2,
    src_pri_pll = 3'h3,
    src_sec = 3'h4,
    src_low_power_internal_rc = 3'h5,
    src_frc_div16 = 3'h6,
    src_frc_div = 3'h7
  } source_t;
endpackage

/* hw/osc_clock_select.sv */
/*
  Oscillator control and clock-select logic with one 32-bit control register
  behind an APB slave, guarded by a two-word unlock sequence.
  Assumes the analog oscillators, PLLs and fail-safe monitor report their
  state on the status inputs; those inputs are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
module osc_clock_select (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [2:0] initial_source_config,
  input wire logic [1:0] switch_monitor_config,
  input wire logic [2:0] init_odiv_config,
  input wire logic [2:0] init_mult_config,
  input wire logic [1:0] init_busdiv_config,
  input wire logic init_sosc_config,
  input wire logic sec_osc_stable,
  input wire logic pri_osc_stable,
  input wire logic usb_pll_lock_in,
  input wire logic sys_pll_lock_in,
  input wire logic clock_fail_detect,
  input wire logic bus_div_busy,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [2:0] current_source,
  output logic [8:0] pll_out_ratio,
  output logic [8:0] fast_rc_ratio,
  output logic [3:0] bus_clock_ratio,
  output logic [4:0] pll_mult_ratio,
  output logic sleep_select,
  output logic usb_rc_clock_select,
  output logic secondary_osc_enable,
  output logic switch_request
);
  import osc_ctrl_pkg::*;

  typedef enum {unl_idle, unl_half, unl_open} unlock_t;
  typedef enum {sw_idle, sw_wait} switch_t;

  // Reset release and status synchronisers
  logic rst_s1_r;
  logic rst_n_r;
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;

  // Register fields
  logic cfg_load_r;
  logic [2:0] odiv_r;
  logic [2:0] fast_rc_divide_r;
  logic [2:0] mult_r;
  logic [2:0] new_r;
  logic [2:0] cur_r;
  logic [1:0] busdiv_r;
  logic lock_r;
  logic sleep_r;
  logic fail_r;
  logic usb_rc_r;
  logic sosc_en_r;
  logic sw_r;

  // Sequencer states
  unlock_t unl_r;
  switch_t sw_st_r;

  // Synchronised status levels
  logic sosc_rdy;
  logic usb_lock;
  logic sys_lock;
  logic fail_in;
  logic pri_rdy;
  logic bus_rdy;

  // Bus strobes and switch control
  logic acc;
  logic wr_ctl;
  logic frozen;
  logic target_ready;
  logic set_sw;
  logic done_sw;
  logic [31:0] ctl_word;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Two-flop synchronisers for analog status inputs
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else if (clk_en) begin
      sync1_r <= {bus_div_busy, pri_osc_stable, clock_fail_detect, sys_pll_lock_in, usb_pll_lock_in,
                  sec_osc_stable};
      sync2_r <= sync1_r;
    end
  end
  assign sosc_rdy = sync2_r[0] & sosc_en_r;
  assign usb_lock = sync2_r[1];
  assign sys_lock = sync2_r[2];
  assign fail_in = sync2_r[3];
  assign pri_rdy = sync2_r[4];
  assign bus_rdy = ~sync2_r[5];

  // Access phase accepted at this edge
  assign acc = psel & penable & pready;

  // Control write counts only straight after a completed unlock
  assign wr_ctl = acc & pwrite & (paddr == oscillator_control_off) & (unl_r == unl_open);

  // Lock freezes selections only when the monitor configuration allows it
  assign frozen = switch_monitor_config[1] & lock_r;

  // Readiness of the requested source
  always_comb begin
    case (new_r)
      src_frc_pll: target_ready = sys_lock;
      src_pri: target_ready = pri_rdy;
      src_pri_pll: target_ready = pri_rdy & sys_lock;
      src_sec: target_ready = sosc_rdy;
      default: target_ready = 1'b1;
    endcase
  end

  // Start strobe: a control write with bit 0 set, unless selections are frozen
  assign set_sw = wr_ctl & pwdata[pos_switch] & ~frozen;

  // Switch ends when the requested source reports ready
  assign done_sw = (sw_st_r == sw_wait) & target_ready;

  // Unlock sequence: two key words then one control write
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      unl_r <= unl_idle;
    end else if (clk_en && acc && pwrite) begin
      case (unl_r)
        unl_idle: unl_r <= (paddr == unlock_key_off && pwdata == key_first) ? unl_half : unl_idle;
        unl_half: unl_r <= (paddr == unlock_key_off && pwdata == key_second) ? unl_open : unl_idle;
        unl_open: unl_r <= unl_idle;
        default: unl_r <= unl_idle;
      endcase
    end
  end

  // Flag that configuration values still need loading after reset release
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cfg_load_r <= 1'b1;
    end else if (clk_en) begin
      cfg_load_r <= 1'b0;
    end
  end

  // Clock and PLL selection fields; source, output divider and multiplier freezable by the lock bit
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      new_r <= src_frc;
      odiv_r <= rst_odiv;
      mult_r <= rst_mult;
      fast_rc_divide_r <= rst_fast_rc_divide;
      busdiv_r <= rst_busdiv;
      sosc_en_r <= 1'b0;
    end else if (clk_en) begin
      if (cfg_load_r) begin
        new_r <= initial_source_config;
        odiv_r <= init_odiv_config;
        mult_r <= init_mult_config;
        busdiv_r <= init_busdiv_config;
        sosc_en_r <= init_sosc_config;
      end else if (wr_ctl) begin
        if (!frozen) begin
          new_r <= pwdata[pos_new +: 3];
          odiv_r <= pwdata[pos_odiv +: 3];
          mult_r <= pwdata[pos_mult +: 3];
        end
        fast_rc_divide_r <= pwdata[pos_fast_rc_divide +: 3];
        if (bus_rdy) begin
          busdiv_r <= pwdata[pos_busdiv +: 2];
        end
        sosc_en_r <= pwdata[pos_sosc_en];
      end
    end
  end

  // Selection lock: sticky, so software cannot undo it until reset
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lock_r <= 1'b0;
    end else if (clk_en && wr_ctl && pwdata[pos_lock]) begin
      lock_r <= 1'b1;
    end
  end

  // Plain control bits
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sleep_r <= 1'b0;
      usb_rc_r <= 1'b0;
    end else if (clk_en && wr_ctl) begin
      sleep_r <= pwdata[pos_sleep];
      usb_rc_r <= pwdata[pos_usb_rc];
    end
  end

  // Clock-fail flag: set on failure, cleared by writing zero; set wins
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fail_r <= 1'b0;
    end else if (clk_en) begin
      if (fail_in) begin
        fail_r <= 1'b1;
      end else if (wr_ctl && !pwdata[pos_fail]) begin
        fail_r <= 1'b0;
      end
    end
  end

  // Switch sequencer: hold current source until target ready
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sw_st_r <= sw_idle;
      sw_r <= 1'b0;
      cur_r <= src_frc;
    end else if (clk_en) begin
      if (cfg_load_r) begin
        cur_r <= initial_source_config;
      end
      case (sw_st_r)
        sw_idle: begin
          if (set_sw) begin
            sw_st_r <= sw_wait;
            sw_r <= 1'b1;
          end
        end
        sw_wait: begin
          if (done_sw) begin
            cur_r <= new_r;
            sw_r <= 1'b0;
            sw_st_r <= sw_idle;
          end
        end
        default: sw_st_r <= sw_idle;
      endcase
    end
  end

  // Register read image; unimplemented bits stay zero
  always_comb begin
    ctl_word = 32'h0000_0000;
    ctl_word[pos_odiv +: 3] = odiv_r;
    ctl_word[pos_fast_rc_divide +: 3] = fast_rc_divide_r;
    ctl_word[pos_sosc_rdy] = sosc_rdy;
    ctl_word[pos_bus_rdy] = bus_rdy;
    ctl_word[pos_busdiv +: 2] = busdiv_r;
    ctl_word[pos_mult +: 3] = mult_r;
    ctl_word[pos_cur +: 3] = cur_r;
    ctl_word[pos_new +: 3] = new_r;
    ctl_word[pos_lock] = lock_r;
    ctl_word[pos_usb_lock] = usb_lock;
    ctl_word[pos_sys_lock] = sys_lock;
    ctl_word[pos_sleep] = sleep_r;
    ctl_word[pos_fail] = fail_r;
    ctl_word[pos_usb_rc] = usb_rc_r;
    ctl_word[pos_sosc_en] = sosc_en_r;
    ctl_word[pos_switch] = sw_r;
  end

  // APB ready: high for the one access cycle that follows each setup
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
    end
  end

  // APB answer: error flag and read data registered at the setup cycle
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (psel && !penable) begin
        pslverr <= (paddr != oscillator_control_off) && (paddr != unlock_key_off) &&
                   (paddr != osc_status_in_off);
        case (paddr)
          oscillator_control_off: prdata <= ctl_word;
          osc_status_in_off: prdata <= {26'h0000000, sync2_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Decoded ratio outputs
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pll_out_ratio <= div_1;
      fast_rc_ratio <= div_2;
      bus_clock_ratio <= 4'h8;
      pll_mult_ratio <= mult_base;
    end else if (clk_en) begin
      pll_out_ratio <= ratio(odiv_r);
      fast_rc_ratio <= ratio(fast_rc_divide_r);
      bus_clock_ratio <= 4'h1 << busdiv_r;
      pll_mult_ratio <= (mult_r == 3'h7) ? mult_top : mult_base + {2'h0, mult_r};
    end
  end

  // Registered copies of the source field and control bits
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      current_source <= src_frc;
      sleep_select <= 1'b0;
      usb_rc_clock_select <= 1'b0;
      secondary_osc_enable <= 1'b0;
      switch_request <= 1'b0;
    end else if (clk_en) begin
      current_source <= cur_r;
      sleep_select <= sleep_r;
      usb_rc_clock_select <= usb_rc_r;
      secondary_osc_enable <= sosc_en_r;
      switch_request <= sw_r;
    end
  end

  // Divide ratio for a 3-bit code: powers of two, top code jumps to 256
  function automatic logic [8:0] ratio(input logic [2:0] code);
    case (code)
      3'h0: ratio = div_1;
      3'h1: ratio = div_2;
      3'h2: ratio = div_4;
      3'h3: ratio = div_8;
      3'h4: ratio = div_16;
      3'h5: ratio = div_32;
      3'h6: ratio = div_64;
      default: ratio = div_256;
    endcase
  endfunction
endmodule
`default_nettype wire

/* tb/osc_clock_select_assertions.sv */
/* Port checker for the oscillator clock-select block.
   Bound to the top module; needs APB traffic from a bench. */
`timescale 1ns/1ns
`default_nettype none
module osc_clock_select_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] current_source,
  input wire logic [8:0] pll_out_ratio,
  input wire logic [4:0] pll_mult_ratio,
  input wire logic sleep_select,
  input wire logic usb_rc_clock_select,
  input wire logic secondary_osc_enable,
  input wire logic switch_request
);
  logic [2:0] up_r;
  // Edges since reset release; checks wait for the config load
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst || up_r != 3'h7);
  sequence s_setup; psel && !penable; endsequence
  sequence s_ctl_rd; pready && !pwrite && paddr == 12'h000; endsequence
  a_ready_wait: assert property (s_setup |=> pready) else $error("no answer");
  a_unmapped_err: assert property (pready && paddr > 12'h008 |-> pslverr && prdata == 32'h0)
    else $error("unmapped");
  a_unimpl_zero: assert property (s_ctl_rd |-> (prdata & 32'hc080_8800) == 32'h0)
    else $error("reserved bits");
  a_odiv_ratio: assert property ($onehot(pll_out_ratio) && !pll_out_ratio[7])
    else $error("divide ratio");
  a_mult_ratio: assert property (pll_mult_ratio inside {[5'h0f:5'h15], 5'h18})
    else $error("multiplier");
  a_sosc_ready: assert property (s_ctl_rd ##0 prdata[22] |-> prdata[1]) else $error("ready off");
  a_copy_match: assert property (s_ctl_rd |-> {current_source, sleep_select, usb_rc_clock_select,
    secondary_osc_enable, switch_request} == {prdata[14:12], prdata[4], prdata[2:0]}) else $error("copy");
  a_cur_switch: assert property ($changed(current_source) |-> $past(switch_request))
    else $error("source moved");
endmodule
bind osc_clock_select osc_clock_select_chk u_chk (.*);
`default_nettype wire

/* tb/osc_clock_select_tb_top.sv */
/* Self-checking bench for the oscillator clock-select block.
   Drives APB and status pins; a monitor checks read data. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("BAD %0t %h %h", $time, a, b); end end
module osc_clock_select_tb_top;
  import osc_ctrl_pkg::*;
  logic sys_clk = 0, nrst = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, init_sosc_config = 0;
  logic sec_osc_stable = 0, pri_osc_stable = 0, usb_pll_lock_in = 0, sys_pll_lock_in = 0;
  logic clock_fail_detect = 0, bus_div_busy = 0, pready, pslverr, sleep_select, usb_rc_clock_select;
  logic secondary_osc_enable, switch_request;
  logic [2:0] initial_source_config = 3'h2, init_odiv_config = 3'h5, init_mult_config = 3'h3, current_source;
  logic [1:0] switch_monitor_config = 2'h2, init_busdiv_config = 2'h3;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, sh, rs = 32'h47fa8d8d;
  logic [8:0] pll_out_ratio, fast_rc_ratio;
  logic [3:0] bus_clock_ratio;
  logic [4:0] pll_mult_ratio;
  logic [32:0] e;
  logic [32:0] exq[$];
  int err_count = 0, checks = 0;
  osc_clock_select u_dut (.*);
  // Clock
  always #10 sys_clk = ~sys_clk;
  function logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [31:0] mk(input logic [2:0] o, f, input logic [1:0] b, input logic [2:0] m, u, n,
    input logic [7:0] l);
    return {2'h0, o, f, 3'h0, b, m, 1'h0, u, 1'h0, n, l};
  endfunction
  function automatic logic [8:0] dv(input logic [2:0] c);
    return c == 3'h7 ? div_256 : 9'h001 << c;
  endfunction
  function automatic logic [4:0] ml(input logic [2:0] c);
    return c == 3'h7 ? mult_top : mult_base + 5'(c);
  endfunction
  task automatic ap(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 50) err_count++;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    exq.push_back(x);
    ap(a, 0, 32'h0);
  endtask
  // Control read; status bits follow the bench's own pins
  task automatic rc();
    rd(oscillator_control_off, {1'b0, sh | {9'h0, sec_osc_stable & sh[1], !bus_div_busy, 14'h0,
      usb_pll_lock_in, sys_pll_lock_in, 5'h0}});
  endtask
  task automatic cw(input logic [31:0] d);
    ap(unlock_key_off, 1, key_first);
    ap(unlock_key_off, 1, key_second);
    ap(oscillator_control_off, 1, d);
  endtask
  task automatic rst();
    nrst <= 0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Compares each read answer with the oldest noted value
  always @(posedge sys_clk)
    if (psel && penable && pready && !pwrite) begin
      e = exq.size() ? exq.pop_front() : 'x;
      `CHK({pslverr, prdata}, e)
    end
  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    final_report();
  end
  // Main sequence
  initial begin
    int k;
    logic [2:0] c;
    rst();
    sh = mk(3'h5, 3'h1, 2'h3, 3'h3, 3'h2, 3'h2, 8'h0);
    rc();
    `CHK({pll_out_ratio, fast_rc_ratio, bus_clock_ratio, pll_mult_ratio}, {9'h020, 9'h002, 4'h8, 5'h12})
    ap(oscillator_control_off, 1, xs());
    rc();
    $display("reset done");
    for (k = 0; k < 8; k++) begin
      c = k[2:0];
      sh = mk(c, ~c, c[1:0], c, 3'h2, 3'h2, {3'h0, c[0], 1'b0, c[1], 2'h0});
      cw(sh | (xs() & 32'hc0e0_f860));
      rc();
      `CHK({pll_out_ratio, fast_rc_ratio}, {dv(c), dv(~c)})
      `CHK({bus_clock_ratio, pll_mult_ratio}, {4'(dv(c & 3'h3)), ml(c)})
    end
    $display("codes done");
    {sec_osc_stable, usb_pll_lock_in, sys_pll_lock_in, clock_fail_detect} <= 4'hf;
    sh = mk(3'h0, 3'h1, 2'h3, 3'h0, 3'h2, 3'h2, 8'h0a);
    cw(sh & ~32'h8);
    repeat (4) @(posedge sys_clk);
    rc();
    clock_fail_detect <= 0;
    repeat (4) @(posedge sys_clk);
    sh[3] = 0;
    cw(sh);
    rc();
    bus_div_busy <= 1;
    repeat (4) @(posedge sys_clk);
    cw(sh & ~32'h0018_0000);
    rc();
    bus_div_busy <= 0;
    $display("status done");
    sh = mk(3'h0, 3'h1, 2'h3, 3'h0, 3'h2, 3'h3, 8'h03);
    cw(sh);
    rc();
    pri_osc_stable <= 1;
    k = 0;
    while (switch_request !== 1'b0 && k < 50) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 50) err_count++;
    sh = mk(3'h0, 3'h1, 2'h3, 3'h0, 3'h3, 3'h3, 8'h02);
    rc();
    `CHK(current_source, 3'h3)
    sh = mk(3'h0, 3'h1, 2'h3, 3'h0, 3'h3, 3'h0, 8'h82);
    cw(sh);
    cw(mk(3'h7, 3'h2, 2'h3, 3'h7, 3'h3, 3'h5, 8'h03));
    sh[26:24] = 3'h2;
    rc();
    // A fail pulse while the clock enable is low must leave no trace
    clk_en <= 0;
    clock_fail_detect <= 1;
    repeat (6) @(posedge sys_clk);
    clock_fail_detect <= 0;
    repeat (2) @(posedge sys_clk);
    clk_en <= 1;
    rc();
    $display("switch done");
    initial_source_config <= 3'h5;
    switch_monitor_config <= 2'h0;
    init_odiv_config <= 3'h7;
    init_mult_config <= 3'h7;
    rst();
    sh = mk(3'h7, 3'h1, 2'h3, 3'h7, 3'h5, 3'h5, 8'h0);
    rc();
    cw(sh | 32'h80);
    sh = mk(3'h2, 3'h1, 2'h3, 3'h1, 3'h5, 3'h0, 8'h80);
    cw(sh);
    rc();
    // Switch to the secondary source waits until it is enabled and stable
    sh = mk(3'h2, 3'h1, 2'h3, 3'h1, 3'h5, 3'h4, 8'h81);
    cw(sh);
    rc();
    sh = mk(3'h2, 3'h1, 2'h3, 3'h1, 3'h4, 3'h4, 8'h82);
    cw(sh);
    repeat (2) @(posedge sys_clk);
    rc();
    rd(12'h00c, 33'h1_0000_0000);
    $display("lock done");
    final_report();
  end
endmodule
`default_nettype wire
